// [src/pwm_dac_top.sv]
// Three-channel PWM converter sharing one counter with an alternate interval timer.
// Assumes a 20 MHz ref_clk, an Avalon-MM master, and external pull-ups on the open-drain pins.
`timescale 1ns/1ns
// How it works
// - After power-on reset the three pins are plain port outputs driving low.
// - Power-on reset, watchdog/stack reset and clock stop load every duty register with 1FFH.
// - A watchdog/stack reset treats the block like power-on reset: port mode, pins low.
// - A chip-enable reset leaves pins, pin mode, registers and counter untouched.
// - During chip-enable reset or halt the waveform and the alternate timer keep running.
// - Entering halt changes neither pin mode, pin levels, counting nor duty contents.
// - Clock stop returns the pins to port mode, each driving its kept output latch value.
// - Timer-select clear gives the counter to the PWM function, set gives it to the timer.
// - With timer-select clear, a set pin-function bit routes its channel's waveform out; clear drives the port latch.
// - In wide mode duty spans 0.25/512 to 511.25/512, so zero still gives a short pulse.
// - Writing clear and enable together zeroes the counter and starts it counting.
// - A channel is high while its duty exceeds the counter and low once the counter exceeds it.
// - One bit selects an 8- or 9-bit counter, another the 1.125 MHz or 112.5 kHz count clock.
module pwm_dac_top (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic watchdog_stack_reset,
	input wire logic chip_enable_reset,
	input wire logic halt_status,
	input wire logic clock_stop,
	input wire logic [2:0] chan_pin_in,
	output logic [2:0] chan_pin_out,
	output logic [2:0] chan_pin_oe
);
	pwm_dac_pkg::bus_state_type bus_state_reg;
	pwm_dac_pkg::bus_state_type bus_state_next;
	logic [31:0] readdata_next;
	logic wr_fire;
	logic clear_fire;
	logic block_reset;
	logic timer_select_bit;
	logic counter_enable_bit;
	logic counter_width_select;
	logic count_clock_select;
	logic [2:0] pin_func_reg;
	logic [2:0] port_latch_reg;
	logic [8:0] duty_reg [pwm_dac_pkg::CHAN_COUNT];
	logic [8:0] count_reg;
	logic [17:0] phase_reg;
	logic [17:0] phase_sum;
	logic [17:0] phase_step;
	logic phase_tick;
	logic first_quarter;
	logic timer_wrap;
	logic pwm_wrap;
	logic timer_match_reg;
	logic [2:0] pwm_level;
	logic [2:0] pin_level_next;

	// Whole-block reset: power-on or watchdog/stack; chip-enable reset is deliberately absent
	assign block_reset = !rst_b || watchdog_stack_reset;

	// Open-drain pins never drive high; the enable pulls the line low
	assign chan_pin_out = 3'h0;

	// Bus handshake: one wait cycle, then the answer with registered read data
	always_comb begin
		bus_state_next = bus_state_reg;
		unique case (bus_state_reg)
			pwm_dac_pkg::BUS_IDLE: begin
				if (avs_read || avs_write) begin
					bus_state_next = pwm_dac_pkg::BUS_ANSWER;
				end
			end
			pwm_dac_pkg::BUS_ANSWER: begin
				bus_state_next = pwm_dac_pkg::BUS_IDLE;
			end
			default: begin
				bus_state_next = pwm_dac_pkg::BUS_IDLE;
			end
		endcase
	end

	assign avs_waitrequest = (avs_read || avs_write) && (bus_state_reg != pwm_dac_pkg::BUS_ANSWER);
	assign wr_fire = avs_write && (bus_state_reg == pwm_dac_pkg::BUS_ANSWER);
	assign clear_fire = wr_fire && (avs_address == pwm_dac_pkg::CTRL_OFFSET) &&
		avs_byteenable[0] && avs_writedata[pwm_dac_pkg::CTRL_CLEAR_POS];

	// Handshake state register
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			bus_state_reg <= pwm_dac_pkg::BUS_IDLE;
		end else begin
			bus_state_reg <= bus_state_next;
		end
	end

	// Read mux; unmapped offsets read as zero
	always_comb begin
		readdata_next = 32'h0000_0000;
		unique case (avs_address)
			pwm_dac_pkg::CTRL_OFFSET: begin
				readdata_next[pwm_dac_pkg::CTRL_ENABLE_POS] = counter_enable_bit;
				readdata_next[pwm_dac_pkg::CTRL_TIMER_SEL_POS] = timer_select_bit;
			end
			pwm_dac_pkg::CLOCK_SEL_OFFSET: begin
				readdata_next[pwm_dac_pkg::CLK_SLOW_POS] = count_clock_select;
				readdata_next[pwm_dac_pkg::CLK_WIDTH_POS] = counter_width_select;
			end
			pwm_dac_pkg::PIN_FUNC_OFFSET: readdata_next[2:0] = pin_func_reg;
			pwm_dac_pkg::PORT_LATCH_OFFSET: readdata_next[2:0] = port_latch_reg;
			pwm_dac_pkg::DUTY0_OFFSET: readdata_next[8:0] = duty_reg[0];
			pwm_dac_pkg::DUTY1_OFFSET: readdata_next[8:0] = duty_reg[1];
			pwm_dac_pkg::DUTY2_OFFSET: readdata_next[8:0] = duty_reg[2];
			pwm_dac_pkg::COUNT_OFFSET: readdata_next[8:0] = count_reg;
			pwm_dac_pkg::STATUS_OFFSET: begin
				readdata_next[pwm_dac_pkg::STATUS_PIN_LSB +: 3] = ~chan_pin_oe;
				readdata_next[pwm_dac_pkg::STATUS_PIN_IN_LSB +: 3] = chan_pin_in;
				readdata_next[pwm_dac_pkg::STATUS_MATCH_POS] = timer_match_reg;
			end
			default: readdata_next = 32'h0000_0000;
		endcase
	end

	// Read data captured in the wait cycle, valid while waitrequest is low
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && bus_state_reg == pwm_dac_pkg::BUS_IDLE) begin
			avs_readdata <= readdata_next;
		end
	end

	// Control bits; clock stop halts counting, halt and chip-enable reset leave them alone
	always_ff @(posedge ref_clk) begin
		if (block_reset) begin
			timer_select_bit <= 1'b0;
			counter_enable_bit <= 1'b0;
		end else if (clock_stop) begin
			counter_enable_bit <= 1'b0;
		end else if (wr_fire && avs_address == pwm_dac_pkg::CTRL_OFFSET && avs_byteenable[0]) begin
			timer_select_bit <= avs_writedata[pwm_dac_pkg::CTRL_TIMER_SEL_POS];
			counter_enable_bit <= avs_writedata[pwm_dac_pkg::CTRL_ENABLE_POS];
		end
	end

	// Counter width and count clock selection
	always_ff @(posedge ref_clk) begin
		if (block_reset) begin
			counter_width_select <= 1'b0;
			count_clock_select <= 1'b0;
		end else if (wr_fire && avs_address == pwm_dac_pkg::CLOCK_SEL_OFFSET &&
				avs_byteenable[0]) begin
			counter_width_select <= avs_writedata[pwm_dac_pkg::CLK_WIDTH_POS];
			count_clock_select <= avs_writedata[pwm_dac_pkg::CLK_SLOW_POS];
		end
	end

	// Pin function bits; clock stop forces port mode
	always_ff @(posedge ref_clk) begin
		if (block_reset || clock_stop) begin
			pin_func_reg <= pwm_dac_pkg::PIN_FUNC_RESET;
		end else if (wr_fire && avs_address == pwm_dac_pkg::PIN_FUNC_OFFSET && avs_byteenable[0]) begin
			pin_func_reg <= avs_writedata[2:0];
		end
	end

	// Port output latches; clock stop keeps them so pins show the old latch value
	always_ff @(posedge ref_clk) begin
		if (block_reset) begin
			port_latch_reg <= pwm_dac_pkg::PORT_LATCH_RESET;
		end else if (wr_fire && avs_address == pwm_dac_pkg::PORT_LATCH_OFFSET &&
				avs_byteenable[0]) begin
			port_latch_reg <= avs_writedata[2:0];
		end
	end

	// Duty registers; duty 2 doubles as the timer modulo value
	always_ff @(posedge ref_clk) begin
		if (block_reset || clock_stop) begin
			for (int i = 0; i < pwm_dac_pkg::CHAN_COUNT; i++) begin
				duty_reg[i] <= pwm_dac_pkg::DUTY_RESET;
			end
		end else if (wr_fire) begin
			for (int i = 0; i < pwm_dac_pkg::CHAN_COUNT; i++) begin
				if (avs_address == pwm_dac_pkg::DUTY0_OFFSET + 6'(4 * i)) begin
					if (avs_byteenable[0]) begin
						duty_reg[i][7:0] <= avs_writedata[7:0];
					end
					if (avs_byteenable[1]) begin
						duty_reg[i][8] <= avs_writedata[8];
					end
				end
			end
		end
	end

	// Fractional divider making the 1.125 MHz or 112.5 kHz basic clock tick
	always_comb begin
		phase_step = count_clock_select ? pwm_dac_pkg::PHASE_STEP_SLOW :
			pwm_dac_pkg::PHASE_STEP_FAST;
		phase_sum = phase_reg + phase_step;
		phase_tick = (phase_sum >= pwm_dac_pkg::PHASE_MODULUS);
		first_quarter = (phase_reg < pwm_dac_pkg::PHASE_QUARTER);
	end

	always_ff @(posedge ref_clk) begin
		if (block_reset || clear_fire) begin
			phase_reg <= 18'h00000;
		end else if (counter_enable_bit) begin
			phase_reg <= phase_tick ? phase_sum - pwm_dac_pkg::PHASE_MODULUS : phase_sum;
		end
	end

	// Wrap points: timer wraps at its modulo, PWM at the selected maximum
	always_comb begin
		timer_wrap = (count_reg == {1'b0, duty_reg[2][7:0]}) ||
			(count_reg >= pwm_dac_pkg::COUNT_MAX_NARROW);
		pwm_wrap = count_reg >= (counter_width_select ? pwm_dac_pkg::COUNT_MAX_WIDE :
			pwm_dac_pkg::COUNT_MAX_NARROW);
	end

	// Shared counter; halt and chip-enable reset do not stop it
	always_ff @(posedge ref_clk) begin
		if (block_reset || clear_fire) begin
			count_reg <= 9'h000;
		end else if (counter_enable_bit && phase_tick) begin
			if (timer_select_bit ? timer_wrap : pwm_wrap) begin
				count_reg <= 9'h000;
			end else begin
				count_reg <= count_reg + 9'h001;
			end
		end
	end

	// Timer match flag: set by hardware, cleared by writing one; a new match wins
	always_ff @(posedge ref_clk) begin
		if (block_reset) begin
			timer_match_reg <= 1'b0;
		end else if (timer_select_bit && counter_enable_bit && phase_tick && timer_wrap) begin
			timer_match_reg <= 1'b1;
		end else if (wr_fire && avs_address == pwm_dac_pkg::STATUS_OFFSET && avs_byteenable[1] &&
				avs_writedata[pwm_dac_pkg::STATUS_MATCH_POS]) begin
			timer_match_reg <= 1'b0;
		end
	end

	// Three comparator channels
	for (genvar g = 0; g < pwm_dac_pkg::CHAN_COUNT; g++) begin : gen_chan
		pwm_compare_channel u_chan (
			.ref_clk(ref_clk),
			.rst_b(rst_b),
			.hold_low(watchdog_stack_reset),
			.duty(duty_reg[g]),
			.count(count_reg),
			.wide_mode(counter_width_select),
			.first_quarter(first_quarter),
			.pwm_level(pwm_level[g])
		);
	end

	// Output selection: timer mode forces every pin to its latch
	always_comb begin
		for (int i = 0; i < pwm_dac_pkg::CHAN_COUNT; i++) begin
			pin_level_next[i] = (pin_func_reg[i] && !timer_select_bit) ? pwm_level[i] :
				port_latch_reg[i];
		end
	end

	// Registered pin enables; enable high pulls the pin low
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			chan_pin_oe <= 3'h7;
		end else begin
			chan_pin_oe <= ~pin_level_next;
		end
	end

	sequence s_clear_start_write;
		wr_fire && avs_address == pwm_dac_pkg::CTRL_OFFSET && avs_byteenable[0] &&
			avs_writedata[pwm_dac_pkg::CTRL_CLEAR_POS] &&
			avs_writedata[pwm_dac_pkg::CTRL_ENABLE_POS] && !block_reset && !clock_stop;
	endsequence
	sequence s_counting_started;
		(count_reg == 9'h000 && counter_enable_bit);
	endsequence

	property p_por_pins_low;
		@(posedge ref_clk) disable iff (!rst_b)
		$rose(rst_b) |-> (chan_pin_oe == 3'h7 && pin_func_reg == 3'h0);
	endproperty
	a_por_pins_low: assert property (p_por_pins_low) else $error("pins not low after reset");

	property p_duty_reload;
		@(posedge ref_clk) disable iff (!rst_b)
		(watchdog_stack_reset || clock_stop) |=>
			(duty_reg[0] == 9'h1ff && duty_reg[1] == 9'h1ff && duty_reg[2] == 9'h1ff);
	endproperty
	a_duty_reload: assert property (p_duty_reload) else $error("duty not reloaded");

	property p_watchdog_low;
		@(posedge ref_clk) disable iff (!rst_b)
		watchdog_stack_reset |=> (pin_func_reg == 3'h0) ##1 (chan_pin_oe == 3'h7);
	endproperty
	a_watchdog_low: assert property (p_watchdog_low) else $error("watchdog reset left pins");

	property p_ce_keeps;
		@(posedge ref_clk) disable iff (!rst_b)
		(chip_enable_reset && !wr_fire && !watchdog_stack_reset && !clock_stop) |=>
			($stable(pin_func_reg) && $stable(port_latch_reg) && $stable(duty_reg[1]));
	endproperty
	a_ce_keeps: assert property (p_ce_keeps) else $error("chip-enable reset altered state");

	property p_halt_counts;
		@(posedge ref_clk) disable iff (!rst_b)
		((halt_status || chip_enable_reset) && counter_enable_bit && phase_tick &&
			!block_reset && !clock_stop && !clear_fire) |=> (count_reg != $past(count_reg));
	endproperty
	a_halt_counts: assert property (p_halt_counts) else $error("counter stalled in halt");

	property p_halt_keeps;
		@(posedge ref_clk) disable iff (!rst_b)
		(halt_status && !wr_fire && !watchdog_stack_reset && !clock_stop) |=>
			($stable(pin_func_reg) && $stable(duty_reg[0]) && $stable(timer_select_bit));
	endproperty
	a_halt_keeps: assert property (p_halt_keeps) else $error("halt altered block state");

	property p_stop_latch;
		@(posedge ref_clk) disable iff (!rst_b)
		(clock_stop && !watchdog_stack_reset) |=> (pin_func_reg == 3'h0) ##1
			(chan_pin_oe == ~$past(port_latch_reg));
	endproperty
	a_stop_latch: assert property (p_stop_latch) else $error("clock stop pins not from latch");

	property p_timer_forces_port;
		@(posedge ref_clk) disable iff (!rst_b)
		timer_select_bit |=> (chan_pin_oe == ~$past(port_latch_reg));
	endproperty
	a_timer_forces_port: assert property (p_timer_forces_port) else $error("timer mode pin");

	property p_pwm_routed;
		@(posedge ref_clk) disable iff (!rst_b)
		(pin_func_reg[1] && !timer_select_bit) |=> (chan_pin_oe[1] == !$past(pwm_level[1]));
	endproperty
	a_pwm_routed: assert property (p_pwm_routed) else $error("waveform not on pin");

	property p_clear_start;
		@(posedge ref_clk) disable iff (!rst_b)
		s_clear_start_write |=> s_counting_started;
	endproperty
	a_clear_start: assert property (p_clear_start) else $error("counter not cleared and started");

	property p_wrap;
		@(posedge ref_clk) disable iff (!rst_b)
		(!timer_select_bit && counter_enable_bit && phase_tick && !block_reset && !clear_fire &&
			count_reg == (counter_width_select ? 9'h1ff : 9'h0ff)) |=> (count_reg == 9'h000);
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter did not wrap at maximum");

	property p_narrow_limit;
		@(posedge ref_clk) disable iff (!rst_b)
		(!counter_width_select && count_reg <= 9'h0ff) |=> (count_reg <= 9'h0ff);
	endproperty
	a_narrow_limit: assert property (p_narrow_limit) else $error("narrow counter passed 255");
endmodule

// [src/pwm_dac_pkg.sv]
// Constants for the three-channel PWM converter with its shared counter and alternate timer.
// Assumes a 20 MHz reference clock and a byte-addressed Avalon-MM register port.
package pwm_dac_pkg;
	// Register byte offsets
	localparam logic [5:0] CTRL_OFFSET = 6'h00;
	localparam logic [5:0] CLOCK_SEL_OFFSET = 6'h04;
	localparam logic [5:0] PIN_FUNC_OFFSET = 6'h08;
	localparam logic [5:0] PORT_LATCH_OFFSET = 6'h0c;
	localparam logic [5:0] DUTY0_OFFSET = 6'h10;
	localparam logic [5:0] DUTY1_OFFSET = 6'h14;
	localparam logic [5:0] DUTY2_OFFSET = 6'h18;
	localparam logic [5:0] COUNT_OFFSET = 6'h1c;
	localparam logic [5:0] STATUS_OFFSET = 6'h20;

	// Field positions
	localparam int CTRL_CLEAR_POS = 0;
	localparam int CTRL_ENABLE_POS = 1;
	localparam int CTRL_TIMER_SEL_POS = 3;
	localparam int CLK_SLOW_POS = 0;
	localparam int CLK_WIDTH_POS = 2;
	localparam int STATUS_PIN_LSB = 0;
	localparam int STATUS_PIN_IN_LSB = 4;
	localparam int STATUS_MATCH_POS = 8;

	// Reset values and counter limits
	localparam int CHAN_COUNT = 3;
	localparam logic [8:0] DUTY_RESET = 9'h1ff;
	localparam logic [8:0] COUNT_MAX_NARROW = 9'h0ff;
	localparam logic [8:0] COUNT_MAX_WIDE = 9'h1ff;
	localparam logic [2:0] PIN_FUNC_RESET = 3'h0;
	localparam logic [2:0] PORT_LATCH_RESET = 3'h0;

	// Basic count clock made by a fractional phase accumulator
	localparam int REF_CLK_HZ = 20000000;
	localparam int BASIC_FAST_HZ = 1125000;
	localparam int BASIC_SLOW_HZ = 112500;
	localparam int PHASE_UNIT_HZ = 100;
	localparam logic [17:0] PHASE_MODULUS = 18'(REF_CLK_HZ / PHASE_UNIT_HZ);
	localparam logic [17:0] PHASE_STEP_FAST = 18'(BASIC_FAST_HZ / PHASE_UNIT_HZ);
	localparam logic [17:0] PHASE_STEP_SLOW = 18'(BASIC_SLOW_HZ / PHASE_UNIT_HZ);
	localparam logic [17:0] PHASE_QUARTER = 18'(REF_CLK_HZ / PHASE_UNIT_HZ / 4);

	// Bus handshake states
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ANSWER = 2'b10
	} bus_state_type;
endpackage

// [src/pwm_compare_channel.sv]
// One PWM channel: compares its duty value with the shared counter.
// Assumes the counter and quarter-phase flag come from the same clock domain.
`timescale 1ns/1ns
module pwm_compare_channel (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic hold_low,
	input wire logic [8:0] duty,
	input wire logic [8:0] count,
	input wire logic wide_mode,
	input wire logic first_quarter,
	output logic pwm_level
);
	logic [8:0] duty_eff;
	logic high_next;

	// Narrow mode uses only the low eight duty bits
	always_comb begin
		duty_eff = wide_mode ? duty : {1'b0, duty[7:0]};
		high_next = (duty_eff > count) || ((duty_eff == count) && first_quarter);
	end

	// Registered waveform, forced low by resets that clear the block
	always_ff @(posedge ref_clk) begin
		if (!rst_b || hold_low) begin
			pwm_level <= 1'b0;
		end else begin
			pwm_level <= high_next;
		end
	end

	property p_high_above;
		@(posedge ref_clk) disable iff (!rst_b)
		(!hold_low && duty_eff > count) |=> pwm_level;
	endproperty
	a_high_above: assert property (p_high_above) else $error("channel low while duty above count");

	property p_low_below;
		@(posedge ref_clk) disable iff (!rst_b)
		(count > duty_eff) |=> !pwm_level;
	endproperty
	a_low_below: assert property (p_low_below) else $error("channel high while count above duty");

	property p_zero_pulse;
		@(posedge ref_clk) disable iff (!rst_b)
		(!hold_low && duty_eff == count && first_quarter) |=> pwm_level;
	endproperty
	a_zero_pulse: assert property (p_zero_pulse) else $error("quarter-step offset pulse missing");
endmodule

// [verif/pwm_pullup_load.sv]
// External load on the three open-drain converter pins: one pull-up resistor each.
// Assumes the device only ever pulls a pin low and releases it otherwise.
`timescale 1ns/1ns
module pwm_pullup_load (
	input wire logic [2:0] pin_out,
	input wire logic [2:0] pin_oe,
	output logic [2:0] pin_level
);
	// A released pin rises to the pull-up level, a driven pin follows its driver
	assign pin_level = (pin_oe & pin_out) | ~pin_oe;
endmodule

// [verif/pwm_dac_mode_and_reset_states_tb.sv]
// Self-checking bench for the three-channel PWM converter and its reset behaviour.
// Assumes the design top, its package and the pull-up load model are compiled first.
`timescale 1ns/1ns
module pwm_dac_mode_and_reset_states_tb;
	typedef struct {logic [5:0] a; logic [31:0] d; logic [31:0] e;} row_type;
	logic ref_clk, rst_b, avs_read, avs_write, avs_waitrequest;
	logic [5:0] avs_address;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic watchdog_stack_reset, chip_enable_reset, halt_status, clock_stop;
	logic [2:0] chan_pin_in, chan_pin_out, chan_pin_oe;
	int error_cnt = 0;
	int tests_run = 0;
	int hi [3];
	row_type rows [6] = '{
		'{pwm_dac_pkg::DUTY0_OFFSET, 32'h1a5, 32'h1a5},
		'{pwm_dac_pkg::DUTY1_OFFSET, 32'h3ff, 32'h1ff},
		'{pwm_dac_pkg::COUNT_OFFSET, 32'h55, 32'h0},
		'{pwm_dac_pkg::CLOCK_SEL_OFFSET, 32'h5, 32'h5},
		'{pwm_dac_pkg::PIN_FUNC_OFFSET, 32'hf, 32'h7},
		'{6'h24, 32'hff, 32'h0}};

	pwm_dac_top pwm_dac_top_inst (.ref_clk(ref_clk), .rst_b(rst_b), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .watchdog_stack_reset(watchdog_stack_reset),
		.chip_enable_reset(chip_enable_reset), .halt_status(halt_status),
		.clock_stop(clock_stop), .chan_pin_in(chan_pin_in), .chan_pin_out(chan_pin_out),
		.chan_pin_oe(chan_pin_oe));
	pwm_pullup_load pwm_pullup_load_inst (.pin_out(chan_pin_out), .pin_oe(chan_pin_oe),
		.pin_level(chan_pin_in));

	// 20 MHz reference clock
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask

	// Tolerance compare for measured values; an unknown seen value still mismatches
	task near(input string name, input logic [31:0] seen, input int exp, input int tol);
		check(name, ($signed(seen) >= exp - tol && $signed(seen) <= exp + tol) ? 32'(exp) : seen,
			32'(exp));
	endtask

	task end_sim;
		$display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// One Avalon transfer; request held until waitrequest is sampled low at a rising edge
	task bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= ~w;
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0) begin
			@(posedge ref_clk);
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d, rd);
	endtask

	task rdchk(input string name, input logic [5:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, rd);
		check(name, rd, e);
	endtask

	// Counts high cycles on each pin over a window
	task measure(input int w);
		hi = '{0, 0, 0};
		repeat (w) begin
			@(negedge ref_clk);
			for (int i = 0; i < 3; i++) hi[i] += int'(chan_pin_in[i] === 1'b1);
		end
	endtask

	// Cuts a hang short well past the expected run length
	initial begin
		repeat (80000) @(posedge ref_clk);
		error_cnt++;
		$display("unexpected hang: run did not finish in time");
		end_sim;
	end

	// Main sequence
	initial begin
		rst_b = 1'b0;
		avs_address = 6'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_byteenable = 4'hf;
		avs_writedata = 32'h0;
		watchdog_stack_reset = 1'b0;
		chip_enable_reset = 1'b0;
		halt_status = 1'b0;
		clock_stop = 1'b0;
		repeat (8) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(negedge ref_clk);
		check("oe after reset", 32'(chan_pin_oe), 32'h7);
		for (int i = 0; i < 3; i++) begin
			rdchk("duty reset", pwm_dac_pkg::DUTY0_OFFSET + 6'(4 * i), 32'h1ff);
		end
		rdchk("pin func reset", pwm_dac_pkg::PIN_FUNC_OFFSET, 32'h0);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rdchk("register row", rows[i].a, rows[i].e);
		end
		// Port mode: pins follow the port latch
		wr(pwm_dac_pkg::PIN_FUNC_OFFSET, 32'h0);
		wr(pwm_dac_pkg::PORT_LATCH_OFFSET, 32'h5);
		repeat (3) @(negedge ref_clk);
		check("port pins", 32'(chan_pin_in), 32'h5);
		rdchk("status pins", pwm_dac_pkg::STATUS_OFFSET, 32'h55);
		// Count clock rates: ticks seen in about 1000 cycles, then restart
		for (int s = 0; s < 2; s++) begin
			wr(pwm_dac_pkg::CLOCK_SEL_OFFSET, 32'(s));
			wr(pwm_dac_pkg::CTRL_OFFSET, 32'h3);
			repeat (1000) @(negedge ref_clk);
			bus(1'b0, pwm_dac_pkg::COUNT_OFFSET, 32'h0, rd);
			near("count rate", rd, (s == 1) ? 6 : 56, 1);
		end
		wr(pwm_dac_pkg::CTRL_OFFSET, 32'h3);
		bus(1'b0, pwm_dac_pkg::COUNT_OFFSET, 32'h0, rd);
		near("restart", rd, 0, 1);
		// Wide mode over two periods with chip-enable reset and halt held
		wr(pwm_dac_pkg::CLOCK_SEL_OFFSET, 32'h4);
		wr(pwm_dac_pkg::DUTY0_OFFSET, 32'h0);
		wr(pwm_dac_pkg::DUTY1_OFFSET, 32'h100);
		wr(pwm_dac_pkg::DUTY2_OFFSET, 32'h1ff);
		wr(pwm_dac_pkg::PIN_FUNC_OFFSET, 32'h7);
		wr(pwm_dac_pkg::CTRL_OFFSET, 32'h3);
		chip_enable_reset <= 1'b1;
		halt_status <= 1'b1;
		measure(18204);
		near("duty zero", hi[0], 9, 8);
		near("duty half", hi[1], 9111, 30);
		near("duty full low", 18204 - hi[2], 27, 10);
		@(posedge ref_clk);
		chip_enable_reset <= 1'b0;
		halt_status <= 1'b0;
		rdchk("duty kept", pwm_dac_pkg::DUTY1_OFFSET, 32'h100);
		rdchk("mode kept", pwm_dac_pkg::PIN_FUNC_OFFSET, 32'h7);
		// Narrow mode: period of 256 ticks
		wr(pwm_dac_pkg::CLOCK_SEL_OFFSET, 32'h0);
		wr(pwm_dac_pkg::DUTY1_OFFSET, 32'h80);
		wr(pwm_dac_pkg::CTRL_OFFSET, 32'h3);
		measure(9102);
		near("narrow duty", hi[1], 4560, 30);
		// Timer selected: pins fall back to the latch, counter runs to its modulo
		wr(pwm_dac_pkg::DUTY2_OFFSET, 32'h10);
		wr(pwm_dac_pkg::CTRL_OFFSET, 32'hb);
		repeat (3) @(negedge ref_clk);
		measure(600);
		near("timer pin0", hi[0], 600, 0);
		near("timer pin1", hi[1], 0, 0);
		bus(1'b0, pwm_dac_pkg::STATUS_OFFSET, 32'h0, rd);
		check("timer match", 32'(rd[8]), 32'h1);
		// Back to PWM, then the match flag clears by writing one to it
		wr(pwm_dac_pkg::CTRL_OFFSET, 32'h3);
		wr(pwm_dac_pkg::STATUS_OFFSET, 32'h100);
		bus(1'b0, pwm_dac_pkg::STATUS_OFFSET, 32'h0, rd);
		check("match clear", 32'(rd[8]), 32'h0);
		// Clock stop while PWM runs: latch value appears, duties back to maximum
		wr(pwm_dac_pkg::PORT_LATCH_OFFSET, 32'h6);
		@(posedge ref_clk);
		clock_stop <= 1'b1;
		@(posedge ref_clk);
		clock_stop <= 1'b0;
		repeat (3) @(negedge ref_clk);
		measure(300);
		check("stop pins", 32'({8'(hi[2]), 8'(hi[1]), 8'(hi[0])}), 32'h2c2c00);
		rdchk("stop mode", pwm_dac_pkg::PIN_FUNC_OFFSET, 32'h0);
		rdchk("stop latch", pwm_dac_pkg::PORT_LATCH_OFFSET, 32'h6);
		rdchk("stop duty", pwm_dac_pkg::DUTY0_OFFSET, 32'h1ff);
		// Watchdog reset in mid-run
		wr(pwm_dac_pkg::PIN_FUNC_OFFSET, 32'h7);
		wr(pwm_dac_pkg::CTRL_OFFSET, 32'h3);
		wr(pwm_dac_pkg::DUTY0_OFFSET, 32'h5);
		@(posedge ref_clk);
		watchdog_stack_reset <= 1'b1;
		@(posedge ref_clk);
		watchdog_stack_reset <= 1'b0;
		repeat (3) @(negedge ref_clk);
		check("watchdog oe", 32'(chan_pin_oe), 32'h7);
		rdchk("watchdog duty", pwm_dac_pkg::DUTY0_OFFSET, 32'h1ff);
		rdchk("watchdog mode", pwm_dac_pkg::PIN_FUNC_OFFSET, 32'h0);
		rdchk("watchdog latch", pwm_dac_pkg::PORT_LATCH_OFFSET, 32'h0);
		// Chip-enable reset alone leaves pins and latch alone
		wr(pwm_dac_pkg::PORT_LATCH_OFFSET, 32'h3);
		@(posedge ref_clk);
		chip_enable_reset <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chip_enable_reset <= 1'b0;
		@(negedge ref_clk);
		check("ce pins", 32'(chan_pin_in), 32'h3);
		rdchk("ce latch", pwm_dac_pkg::PORT_LATCH_OFFSET, 32'h3);
		// Second power-on reset in mid-run
		wr(pwm_dac_pkg::PIN_FUNC_OFFSET, 32'h7);
		wr(pwm_dac_pkg::DUTY2_OFFSET, 32'h22);
		@(posedge ref_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		@(negedge ref_clk);
		check("oe after reset", 32'(chan_pin_oe), 32'h7);
		rdchk("duty2 reset", pwm_dac_pkg::DUTY2_OFFSET, 32'h1ff);
		end_sim;
	end
endmodule
